// file: dv/mbcfg_master_model.sv
// master model for the slave port: frames, link writes, reply completion
// assumes the slave samples every input on the rising core clock edge
`timescale 1ns/1ps
`default_nettype none

module mbcfg_master_model #(
   parameter int HOLD_CYC = 2000000
) (
   input wire logic clk, // core clock
   input wire logic reply_req, // slave starts a reply
   output var mbcfg_pkg::mbcfg_wr_t link_wr, // setting write received on the link
   output var logic frame_valid, // header present
   output var mbcfg_pkg::mbcfg_hdr_t frame_hdr, // station and register address
   output var logic reply_done // reply fully sent
);
   int lat = 1;
   int cnt = 0;
   initial begin
      link_wr = '0;
      frame_valid = 1'b0;
      frame_hdr = '0;
      reply_done = 1'b0;
   end
   // ==========================================================
   // transmitter stand-in; lat picks a prompt or a slow reply
   always @(posedge clk) begin
      reply_done <= !reply_req && cnt == 1;
      cnt <= reply_req ? lat : (cnt > 0 ? cnt - 1 : 0);
   end
   // ==========================================================
   // frames may carry the broadcast station as well as real ones
   task automatic send_frame(input logic [7:0] st, input logic [15:0] ra);
      @(posedge clk) #1;
      frame_hdr = {st, ra};
      frame_valid = 1'b1;
      @(posedge clk) #1;
      frame_valid = 1'b0;
      // released header must not keep looking valid
      frame_hdr = ~frame_hdr;
   endtask : send_frame
   task automatic link_write(input mbcfg_pkg::mbcfg_sel_t s, input logic [7:0] d);
      @(posedge clk) #1;
      link_wr = {1'b1, s, d};
      @(posedge clk) #1;
      link_wr = '0;
   endtask : link_write
   // quiet time before speaking with a new format or rate
   task automatic hold_off();
      repeat (HOLD_CYC) @(posedge clk);
   endtask : hold_off
endmodule : mbcfg_master_model

`default_nettype wire

// file: dv/modbus_rtu_slave_port_config_bench.sv
// bench for the slave-port configuration: staging, apply, framing, frames, decode
// assumes mbcfg_master_model on the link side and a 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none

module modbus_rtu_slave_port_config_bench;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ser_reset_req = 1'b0;
   mbcfg_pkg::mbcfg_wr_t kp_wr = '0;
   mbcfg_pkg::mbcfg_wr_t opt_wr = '0;
   mbcfg_pkg::mbcfg_wr_t link_wr;
   mbcfg_pkg::mbcfg_hdr_t frame_hdr;
   logic frame_valid, reply_done, stop2, par_en, par_odd, d7, pend, acc, req, busy, ok;
   logic [3:0] fmt_s, rate_s, fmt_a, rate_a;
   logic [7:0] st_s, st_a, menu, param;
   logic [31:0] seed = 32'h5b70;
   logic [15:0] ra;
   logic [16:0] e;
   logic [15:0] cor [6] = '{16'd16298, 16'd16299, 16'd16382, 16'd16383, 16'd99, 16'd1023};
   logic [7:0] sv [4] = '{8'h00, 8'hF8, 8'hF7, 8'h05};
   int se [4] = '{1, 1, 247, 5};
   int fail_count = 0;
   int checks = 0;
   int pf = 0;
   int pr = 6;
   int sr;

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   mbcfg_top u_mbcfg_top (.core_clk(core_clk), .rst_b(rst_b), .kp_wr(kp_wr), .opt_wr(opt_wr),
      .link_wr(link_wr), .ser_reset_req(ser_reset_req), .frame_valid(frame_valid),
      .frame_hdr(frame_hdr), .reply_done(reply_done), .link_format_param_r(fmt_s),
      .link_bitrate_param_r(rate_s), .station_param_r(st_s), .act_format_r(fmt_a),
      .act_bitrate_r(rate_a), .act_station_r(st_a), .stop2_r(stop2), .parity_en_r(par_en),
      .parity_odd_r(par_odd), .data7_r(d7), .apply_pend_r(pend), .frame_accept_r(acc),
      .reply_req_r(req), .reply_busy_r(busy), .menu_number_r(menu), .param_number_r(param),
      .reg_ok_r(ok));
   mbcfg_master_model #(.HOLD_CYC(50)) u_mbcfg_master_model (.clk(core_clk), .reply_req(req),
      .link_wr(link_wr), .frame_valid(frame_valid), .frame_hdr(frame_hdr),
      .reply_done(reply_done));

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   // expected {reachable, menu, parameter}; parameter zero never reachable
   function automatic logic [16:0] dec(input logic m, input logic [15:0] a);
      int n;
      int mn;
      int pn;
      n = int'(a) + 1;
      mn = m ? n / 256 : n / 100;
      pn = m ? n % 256 : n % 100;
      return {mn <= (m ? 63 : 162) && pn != 0, mn[7:0], pn[7:0]};
   endfunction : dec
   function automatic mbcfg_pkg::mbcfg_wr_t wr(input mbcfg_pkg::mbcfg_sel_t s, input int d);
      return {1'b1, s, 8'(d)};
   endfunction : wr
   task automatic chk_val(input logic [7:0] got, input int exp);
      checks++;
      if (got !== 8'(exp)) begin
         fail_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, 8'(exp));
      end
   endtask : chk_val
   task automatic chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_flag
   task automatic results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic setw(input mbcfg_pkg::mbcfg_wr_t k, input mbcfg_pkg::mbcfg_wr_t o);
      @(posedge core_clk) #1;
      kp_wr = k;
      opt_wr = o;
      @(posedge core_clk) #1;
      kp_wr = '0;
      opt_wr = '0;
   endtask : setw
   task automatic apply();
      @(posedge core_clk) #1;
      ser_reset_req = 1'b1;
      @(posedge core_clk) #1;
      ser_reset_req = 1'b0;
   endtask : apply
   task automatic chk_act();
      chk_val(fmt_a, pf);
      chk_val(rate_a, pr);
      chk_flag(stop2, pf[1:0] == 0);
      chk_flag(par_en, pf[1]);
      chk_flag(par_odd, pf[1:0] == 3);
      chk_flag(d7, 1'b0);
   endtask : chk_act
   task automatic frame(input logic [7:0] st, input logic [15:0] a, input logic ea, er);
      u_mbcfg_master_model.send_frame(st, a);
      chk_flag(acc, ea);
      chk_flag(req, er);
   endtask : frame
   // a reply that never ends must not hang the run
   task automatic wait_idle();
      int n;
      n = 0;
      // busy only rises one cycle after the reply request
      @(posedge core_clk) #1;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge core_clk) #1;
         n++;
      end
      if (n == 100) begin
         fail_count++;
         $display("[FAIL] %0t reply never ended", $time);
         results();
      end
   endtask : wait_idle

   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      $display("[FAIL] %0t run limit reached", $time);
      results();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge core_clk);
      chk_val(fmt_s, 0);
      chk_val(st_a, 1);
      chk_act();
      $display("test reset ends");
      for (int f = 0; f < 16; f++) begin
         setw(wr(mbcfg_pkg::MBCFG_SEL_FORMAT, f), '0);
         chk_val(fmt_s, f % 8);
         chk_act();
         apply();
         pf = f % 8;
         chk_act();
      end
      $display("test formats ends");
      setw(wr(mbcfg_pkg::MBCFG_SEL_BITRATE, 3), wr(mbcfg_pkg::MBCFG_SEL_BITRATE, 5));
      chk_val(rate_s, 3);
      u_mbcfg_master_model.link_write(mbcfg_pkg::MBCFG_SEL_BITRATE, 8'h09);
      chk_val(rate_s, 9);
      sr = 9;
      for (int i = 0; i < 12; i++) begin
         ra = 16'(xs() % 16);
         setw(wr(mbcfg_pkg::MBCFG_SEL_BITRATE, int'(ra)), '0);
         if (ra < 10) sr = int'(ra);
         chk_val(rate_s, sr);
      end
      foreach (sv[i]) begin
         setw('0, wr(mbcfg_pkg::MBCFG_SEL_ADDR, int'(sv[i])));
         chk_val(st_s, se[i]);
      end
      apply();
      pr = sr;
      chk_act();
      chk_val(st_a, 5);
      $display("test writes ends");
      for (int m = 0; m < 2; m++) begin
         setw(wr(mbcfg_pkg::MBCFG_SEL_FORMAT, m * 4), '0);
         apply();
         pf = m * 4;
         for (int i = 0; i < 25; i++) begin
            ra = i < 6 ? cor[i] : 16'(xs() % 25600);
            e = dec(m[0], ra);
            frame(8'h00, ra, 1'b1, 1'b0);
            chk_flag(ok, e[16]);
            if (e[16]) begin
               chk_val(menu, int'(e[15:8]));
               chk_val(param, int'(e[7:0]));
            end
         end
      end
      $display("test decode ends");
      u_mbcfg_master_model.lat = 6;
      frame(8'h05, 16'h0000, 1'b1, 1'b1);
      @(posedge core_clk) #1;
      chk_flag(busy, 1'b1);
      frame(8'h05, 16'h0002, 1'b1, 1'b0);
      frame(8'h09, 16'h0002, 1'b0, 1'b0);
      wait_idle();
      u_mbcfg_master_model.lat = 20;
      frame(8'h05, 16'h0001, 1'b1, 1'b1);
      u_mbcfg_master_model.link_write(mbcfg_pkg::MBCFG_SEL_FORMAT, 8'h02);
      u_mbcfg_master_model.link_write(mbcfg_pkg::MBCFG_SEL_BITRATE, 8'h01);
      apply();
      chk_flag(pend, 1'b1);
      chk_act();
      wait_idle();
      @(posedge core_clk) #1;
      pf = 2;
      pr = 1;
      chk_act();
      chk_flag(pend, 1'b0);
      u_mbcfg_master_model.hold_off();
      frame(8'h05, 16'd1001, 1'b1, 1'b1);
      chk_val(menu, 10);
      chk_val(param, 2);
      wait_idle();
      $display("test replies ends");
      results();
   end
endmodule : modbus_rtu_slave_port_config_bench

`default_nettype wire

// file: verilog/mbcfg_pkg.sv
// constants and carrier types for the serial slave-port configuration block
// assumes a single core clock domain; no other package is used
`default_nettype none

package mbcfg_pkg;

   // ===========================================================
   // link format setting
   localparam int FMT_W = 4;
   localparam logic [3:0] FMT_RST = 4'h0; // two stop bits, no parity, standard numbering
   localparam int FMT_PAR_LSB = 0;
   localparam int FMT_PAR_W = 2;
   localparam int FMT_REGMODE_BIT = 2;
   localparam int FMT_DATA7_BIT = 3;
   localparam logic [1:0] FMT_2STOP_NONE = 2'h0;
   localparam logic [1:0] FMT_1STOP_NONE = 2'h1;
   localparam logic [1:0] FMT_1STOP_EVEN = 2'h2;
   localparam logic [1:0] FMT_1STOP_ODD = 2'h3;

   // ===========================================================
   // bit-rate code and station address
   localparam int BR_W = 4;
   localparam logic [3:0] BR_RST = 4'h6;
   localparam logic [3:0] BR_MAX = 4'h9;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_RST = 8'h01;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MAX = 8'hF7;

   // ===========================================================
   // register numbering
   localparam int RA_W = 16;
   localparam logic [16:0] STD_MULT = 17'h0_0064;
   localparam logic [16:0] STD_MENU_MAX = 17'h0_00A2;
   localparam logic [16:0] MOD_MENU_MAX = 17'h0_003F;
   localparam logic [7:0] STD_PARAM_MAX = 8'h63;
   localparam logic [7:0] REACH_MENU_MAX = 8'h3F;

   // ===========================================================
   // carriers
   typedef enum logic [1:0] {
      MBCFG_SEL_FORMAT = 2'b00,
      MBCFG_SEL_BITRATE = 2'b01,
      MBCFG_SEL_ADDR = 2'b10,
      MBCFG_SEL_NONE = 2'b11
   } mbcfg_sel_t;

   typedef struct packed {
      logic valid;
      mbcfg_sel_t sel;
      logic [7:0] data;
   } mbcfg_wr_t;

   typedef struct packed {
      logic [7:0] station;
      logic [15:0] reg_addr;
   } mbcfg_hdr_t;

   typedef enum logic [0:0] {
      MBCFG_AP_IDLE = 1'b0,
      MBCFG_AP_WAIT = 1'b1
   } mbcfg_ap_t;

endpackage : mbcfg_pkg

`default_nettype wire

// file: verilog/mbcfg_regdec.sv
// register-address decoder: maps a slave register address onto menu and parameter
// assumes a synchronised active-low reset from the top; result one cycle after valid
`timescale 1ns/1ps
`default_nettype none

module mbcfg_regdec (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic valid, // header present this cycle
   input wire logic modified, // 1 selects the binary numbering
   input wire logic [15:0] reg_addr, // register address from the frame
   output logic [7:0] menu_r, // decoded menu number
   output logic [7:0] param_r, // decoded parameter number
   output logic ok_r // address maps to a reachable parameter
);

   // ===========================================================
   // decode
   logic [16:0] sum;
   logic [16:0] quo;
   logic [16:0] rem;
   assign sum = {1'b0, reg_addr} + 17'h0_0001;
   assign quo = sum / mbcfg_pkg::STD_MULT;
   assign rem = sum % mbcfg_pkg::STD_MULT;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         menu_r <= 8'h00;
         param_r <= 8'h00;
         ok_r <= 1'b0;
      end else if (valid) begin
         if (modified) begin
            // menu in the high byte, parameter in the low byte
            menu_r <= sum[15:8]; // RL6
            param_r <= sum[7:0];
            ok_r <= (sum <= {mbcfg_pkg::MOD_MENU_MAX[8:0], 8'hFF}) && (sum[7:0] != 8'h00); // RL6
         end else begin
            menu_r <= quo[7:0]; // RL5
            param_r <= rem[7:0];
            ok_r <= (quo <= mbcfg_pkg::STD_MENU_MAX) && (rem != 17'h0_0000); // RL5
         end
      end
   end

   // neither scheme can yield a high menu with a parameter above the decimal range
   no_high_param_a: assert property (@(posedge clk) disable iff (!rst_n)
      ok_r |-> !(menu_r > mbcfg_pkg::REACH_MENU_MAX && param_r > mbcfg_pkg::STD_PARAM_MAX))
      else $error("high menu with wide parameter decoded"); // RL7

endmodule : mbcfg_regdec

`default_nettype wire

// file: verilog/mbcfg_top.sv
// serial slave-port configuration: staged and active link settings, station match
// assumes all inputs except rst_b come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RL1] port speaks one slave protocol only; replies only to received frames, never initiates.
// [RL2] format bits 1:0 choose two-stop none, one-stop none, even or odd.
// [RL3] format bit 2 picks standard decimal or modified binary register numbering.
// [RL4] format bit 3 picks seven data bits; base product holds it at zero.
// [RL5] standard numbering: address equals menu*100 plus parameter minus one.
// [RL6] modified numbering: address equals menu*256 plus parameter minus one.
// [RL7] high menus with parameters above 99 cannot be reached by either scheme.
// [RL8] new settings are staged and take effect only on a serial reset request.
// [RL9] a reply to a format write over the link uses the old format.
// [RL10] a reply to a bit-rate write over the link uses the old rate.
// [RL11] master waits 20 ms before using a new format.
// [RL12] master waits 20 ms before using a new bit rate.
// [RL13] address zero is broadcast; it is never accepted as own address.
// [RL14] reset format is eight data bits, two stop bits, no parity.
// [RL15] settings writable from keypad, option module and the link itself.
// [RL16] act on own or broadcast address only; never reply to broadcast.
module mbcfg_top (
   input wire logic core_clk, // core clock, 100 MHz
   input wire logic rst_b, // asynchronous reset, active low
   input wire mbcfg_pkg::mbcfg_wr_t kp_wr, // keypad setting write
   input wire mbcfg_pkg::mbcfg_wr_t opt_wr, // option-module setting write
   input wire mbcfg_pkg::mbcfg_wr_t link_wr, // setting write received on the link
   input wire logic ser_reset_req, // serial-interface reset request pulse
   input wire logic frame_valid, // received frame header pulse
   input wire mbcfg_pkg::mbcfg_hdr_t frame_hdr, // station and register address
   input wire logic reply_done, // transmitter finished a reply
   output logic [3:0] link_format_param_r, // staged format value
   output logic [3:0] link_bitrate_param_r, // staged bit-rate code
   output logic [7:0] station_param_r, // staged station address
   output logic [3:0] act_format_r, // format in use on the wire
   output logic [3:0] act_bitrate_r, // bit-rate code in use
   output logic [7:0] act_station_r, // station address in use
   output logic stop2_r, // two stop bits in use
   output logic parity_en_r, // parity bit in use
   output logic parity_odd_r, // odd parity when parity in use
   output logic data7_r, // seven data bits
   output logic apply_pend_r, // a reset request waits for a reply to end
   output logic frame_accept_r, // frame addressed to this station, pulse
   output logic reply_req_r, // start a reply, pulse
   output logic reply_busy_r, // reply under way
   output logic [7:0] menu_number_r, // decoded menu number
   output logic [7:0] param_number_r, // decoded parameter number
   output logic reg_ok_r // decoded address reachable
);

   // ===========================================================
   // reset release
   logic rst_q1;
   logic rst_n;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ===========================================================
   // write arbitration: one source a cycle, keypad first
   mbcfg_pkg::mbcfg_wr_t wr;
   always_comb begin
      if (kp_wr.valid) begin
         wr = kp_wr; // RL15
      end else if (opt_wr.valid) begin
         wr = opt_wr; // RL15
      end else begin
         wr = link_wr; // RL15
      end
   end

   // ===========================================================
   // staged settings
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_format_param_r <= mbcfg_pkg::FMT_RST; // RL14
      end else if (wr.valid && wr.sel == mbcfg_pkg::MBCFG_SEL_FORMAT) begin
         // the base product has no seven-bit protocol
         link_format_param_r <= {1'b0, wr.data[2:0]}; // RL4
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_bitrate_param_r <= mbcfg_pkg::BR_RST;
      end else if (wr.valid && wr.sel == mbcfg_pkg::MBCFG_SEL_BITRATE
                   && wr.data[3:0] <= mbcfg_pkg::BR_MAX && wr.data[7:4] == 4'h0) begin
         link_bitrate_param_r <= wr.data[3:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         station_param_r <= mbcfg_pkg::ADDR_RST;
      end else if (wr.valid && wr.sel == mbcfg_pkg::MBCFG_SEL_ADDR
                   && wr.data != mbcfg_pkg::ADDR_BCAST && wr.data <= mbcfg_pkg::ADDR_MAX) begin
         station_param_r <= wr.data; // RL13
      end
   end

   // ===========================================================
   // apply sequencer: a reset request never changes settings mid-reply
   mbcfg_pkg::mbcfg_ap_t ap_st;
   logic apply;
   assign apply = (ap_st == mbcfg_pkg::MBCFG_AP_IDLE && ser_reset_req && !reply_busy_r)
                  || (ap_st == mbcfg_pkg::MBCFG_AP_WAIT && !reply_busy_r);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_st <= mbcfg_pkg::MBCFG_AP_IDLE;
      end else begin
         case (ap_st)
            mbcfg_pkg::MBCFG_AP_IDLE: begin
               if (ser_reset_req && reply_busy_r) begin
                  ap_st <= mbcfg_pkg::MBCFG_AP_WAIT; // RL9 RL10
               end
            end
            mbcfg_pkg::MBCFG_AP_WAIT: begin
               if (!reply_busy_r) begin
                  ap_st <= mbcfg_pkg::MBCFG_AP_IDLE;
               end
            end
            default: begin
               ap_st <= mbcfg_pkg::MBCFG_AP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         apply_pend_r <= 1'b0;
      end else begin
         apply_pend_r <= (ap_st == mbcfg_pkg::MBCFG_AP_IDLE && ser_reset_req && reply_busy_r)
                         || (ap_st == mbcfg_pkg::MBCFG_AP_WAIT && reply_busy_r);
      end
   end

   // ===========================================================
   // active settings
   logic [1:0] par_sel;
   assign par_sel = link_format_param_r[mbcfg_pkg::FMT_PAR_LSB +: mbcfg_pkg::FMT_PAR_W];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_format_r <= mbcfg_pkg::FMT_RST;
         act_bitrate_r <= mbcfg_pkg::BR_RST;
         act_station_r <= mbcfg_pkg::ADDR_RST;
         stop2_r <= 1'b1; // RL14
         parity_en_r <= 1'b0;
         parity_odd_r <= 1'b0;
         data7_r <= 1'b0;
      end else if (apply) begin
         act_format_r <= link_format_param_r; // RL8
         act_bitrate_r <= link_bitrate_param_r; // RL8
         act_station_r <= station_param_r; // RL8
         stop2_r <= (par_sel == mbcfg_pkg::FMT_2STOP_NONE); // RL2
         parity_en_r <= (par_sel == mbcfg_pkg::FMT_1STOP_EVEN)
                        || (par_sel == mbcfg_pkg::FMT_1STOP_ODD); // RL2
         parity_odd_r <= (par_sel == mbcfg_pkg::FMT_1STOP_ODD); // RL2
         data7_r <= link_format_param_r[mbcfg_pkg::FMT_DATA7_BIT]; // RL4
      end
   end

   // ===========================================================
   // station match and reply control; slave only, no frame is ever originated
   logic is_bcast;
   logic is_own;
   assign is_bcast = (frame_hdr.station == mbcfg_pkg::ADDR_BCAST); // RL13
   assign is_own = (frame_hdr.station == act_station_r);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_accept_r <= 1'b0;
         reply_req_r <= 1'b0;
      end else begin
         frame_accept_r <= frame_valid && (is_own || is_bcast); // RL16
         reply_req_r <= frame_valid && is_own && !is_bcast && !reply_busy_r; // RL1 RL16
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reply_busy_r <= 1'b0;
      end else if (reply_req_r) begin
         reply_busy_r <= 1'b1;
      end else if (reply_done) begin
         reply_busy_r <= 1'b0;
      end
   end

   // ===========================================================
   // register numbering
   mbcfg_regdec u_regdec (
      .clk(core_clk),
      .rst_n(rst_n),
      .valid(frame_valid),
      .modified(act_format_r[mbcfg_pkg::FMT_REGMODE_BIT]), // RL3
      .reg_addr(frame_hdr.reg_addr),
      .menu_r(menu_number_r),
      .param_r(param_number_r),
      .ok_r(reg_ok_r)
   );

   // ===========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   fmt_defer_a: assert property (!apply |=> $stable(act_format_r)) // RL8
      else $error("active format changed without apply");
   fmt_apply_a: assert property ($rose(ser_reset_req) && !reply_busy_r
      |=> act_format_r == $past(link_format_param_r)) // RL8
      else $error("format not applied on reset request");
   old_rate_a: assert property (reply_busy_r |=> $stable(act_bitrate_r) || !$past(reply_busy_r))
      else $error("bit rate changed during a reply"); // RL10
   old_fmt_a: assert property (reply_busy_r && $past(reply_busy_r) |-> $stable(act_format_r))
      else $error("format changed during a reply"); // RL9
   bcast_silent_a: assert property (frame_valid && is_bcast |=> frame_accept_r && !reply_req_r)
      else $error("broadcast answered or dropped"); // RL16
   own_addr_nz_a: assert property (act_station_r != mbcfg_pkg::ADDR_BCAST && station_param_r != 8'h00)
      else $error("station address became broadcast"); // RL13
   data8_only_a: assert property (!link_format_param_r[mbcfg_pkg::FMT_DATA7_BIT] && !data7_r)
      else $error("seven data bits selected"); // RL4
   stop_par_a: assert property (stop2_r |-> !parity_en_r)
      else $error("two stop bits with parity"); // RL2
   no_unsolicited_a: assert property (reply_req_r |-> $past(frame_valid) && $past(is_own))
      else $error("reply without an addressed frame"); // RL1
   std_map_a: assert property (frame_valid && !act_format_r[2] && frame_hdr.reg_addr == 16'h0_3E9
      |=> menu_number_r == 8'h0A && param_number_r == 8'h02 && reg_ok_r)
      else $error("standard numbering mismatch"); // RL5
   mod_map_a: assert property (frame_valid && act_format_r[2] && frame_hdr.reg_addr == 16'h0_3FF
      |=> menu_number_r == 8'h04 && param_number_r == 8'h00 && !reg_ok_r)
      else $error("modified numbering mismatch"); // RL6

endmodule : mbcfg_top

`default_nettype wire
